// File: include/cmd_consts.vh
// Purpose: constants for the contact moisture detector
// Assumes: 200 MHz core clock, 6-bit adc codes, current steps 1/4/16/64 ua
// Notes:   times kept in their own unit, cycle counts derived from them
// How it works
// R1 - impedance below threshold raises moisture flags
// R2 - charger output stays disconnected from a wet line
// R3 - threshold equals voltage threshold over target current, default 700 kohm
// R4 - manual request during link waits until link disconnects
// R5 - after slave pulse and signature pulse, launch a measurement
// R6 - three consecutive reduced pulses launch a measurement
// R7 - manual probe request launches measurement, waits while converter drives line
// R8 - periodic enable runs measurement every 16 s, off after reset
// R9 - slave measures every 16 s by default and on its manual bit
// R10 - start lowest current, quadruple while reading below 0x3f minus range
// R11 - report averaged reading and source current used
// R12 - classify result: ground short, moisture, cleared or open
// R13 - abort flag when readings vary significantly
// R14 - wet flag set only by signature, three-pulse and periodic triggers
// R15 - keep pulsing; above 17 kohm moisture removed and flags cleared
// R16 - wet line keeps connection cycling attached to detected, failing
// R17 - retry enable cleared stops master auto retry; slave retry always on
// R18 - trigger during a running measurement is held and serviced afterwards
`ifndef CMD_CONSTS_VH
`define CMD_CONSTS_VH
`define CMD_PERIOD_S        16
`define CMD_CLK_HZ          200000000
// 16 s at 200 mhz, sized: the plain product exceeds the signed 32-bit range
`define CMD_PERIOD_CYC      36'd3200000000
`define CMD_ADC_FULL        6'h3f
`define CMD_PULSE_COUNT     2'h3
`define CMD_THR_RST         8'h46
`define CMD_IP_RST          3'h0
`define CMD_IP_MAX          3'h3
`define CMD_GND_OHM         458
`define CMD_OPEN_OHM        1500000
`define CMD_DRY_OHM         17000
`define CMD_VARY_LIM        6'h04
`endif

// File: src/cmd_classify.v
// Purpose: turn reading and current step into a result class
// Assumes: reading in mv per code of 1 mv scaled by adc_mv_lsb, current 1*4^step ua
// Notes:   combinational; ohm = mv*1000 / ua, compared by cross multiply
`timescale 1ns/1ps
`include "cmd_consts.vh"
module cmd_classify #(
    parameter [7:0] MV_LSB = 8'h10
) (
    // measurement
    input  wire [5:0]  i_adc,
    input  wire [1:0]  i_step,
    // threshold programming
    input  wire [7:0]  i_thr_code,
    input  wire [2:0]  i_ip_code,
    // results
    output wire        o_gnd,
    output wire        o_wet,
    output wire        o_done,
    output wire        o_open,
    output wire        o_dry
);
    // compare in milliohm-free units: v_mv*1e3 against r*i_ua
    wire [13:0] v_mv   = i_adc * MV_LSB;
    wire [6:0]  i_ua   = 7'h1 << {i_step, 1'b0};
    wire [13:0] thr_mv = i_thr_code * 8'h0a;
    wire [6:0]  tgt_ua = 7'h1 << i_ip_code;
    wire [47:0] lhs    = {34'h0, v_mv} * 48'd1000;
    wire [47:0] lhs_t  = lhs * {41'h0, tgt_ua};
    wire [47:0] rhs_t  = {34'h0, thr_mv} * 48'd1000 * {41'h0, i_ua};
    assign o_gnd  = lhs < `CMD_GND_OHM * {41'h0, i_ua};                 // R12
    assign o_wet  = lhs_t < rhs_t;                                      // R1 R3
    assign o_open = lhs > 48'd`CMD_OPEN_OHM * {41'h0, i_ua};            // R12
    assign o_done = !o_wet && !o_open;                                  // R12
    assign o_dry  = lhs > 48'd`CMD_DRY_OHM * {41'h0, i_ua};             // R15
endmodule // cmd_classify

// File: src/cmd_moisture_ctrl.v
// Purpose: per-line moisture probe sequencer for the case side
// Assumes: analog front end returns one adc sample per request
// Notes:   one channel; instantiate twice for two lines
`timescale 1ns/1ps
`include "cmd_consts.vh"
module cmd_moisture_ctrl #(
    parameter [35:0] PERIOD_CYC = `CMD_PERIOD_CYC,
    parameter [7:0]  MV_LSB     = 8'h10
) (
    // clock and reset
    input  wire        i_core_clk,
    input  wire        i_resetn,
    // link events
    input  wire        i_slave_pulse,
    input  wire        i_sig_pulse_sent,
    input  wire        i_reduced_pulse,
    input  wire        i_full_pulse,
    input  wire        i_link_up,
    input  wire        i_link_drop,
    input  wire        i_conv_on_line,
    input  wire        i_detected_phase,
    // configuration
    input  wire        i_manual_probe_request_ch,
    input  wire        i_periodic_probe_enable_ch,
    input  wire        i_auto_retry_enable_ch,
    input  wire [7:0]  i_moisture_voltage_threshold,
    input  wire [2:0]  i_moisture_target_current,
    input  wire [5:0]  i_adc_range_setting,
    // analog front end
    output reg         o_src_en,
    output reg  [1:0]  o_src_step,
    output reg         o_adc_req,
    input  wire        i_adc_valid,
    input  wire [5:0]  i_adc_data,
    // results
    output reg  [5:0]  o_averaged_adc_reading,
    output reg  [6:0]  o_probe_source_current,
    output reg         o_busy,
    output reg         o_res_gnd,
    output reg         o_res_wet,
    output reg         o_res_done,
    output reg         o_res_open,
    output reg         o_res_abort,
    output reg         o_channel_wet_flag,
    output wire        o_conv_connect_allow
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_REQ  = 2'h1;
    localparam [1:0] ST_WAIT = 2'h2;
    localparam [1:0] ST_DONE = 2'h3;

    reg  [1:0] state_r;
    reg  [1:0] step_r;
    reg  [1:0] red_cnt_r;
    reg        pend_auto_r;
    reg        pend_man_r;
    reg        run_auto_r;
    reg        man_prev_r;
    reg  [5:0] first_r;
    reg        first_v_r;
    reg        vary_r;
    reg  [5:0] adc_r;
    wire       tick;
    wire       c_gnd;
    wire       c_wet;
    wire       c_done;
    wire       c_open;
    wire       c_dry;

    cmd_period_timer #(.PERIOD_CYC(PERIOD_CYC)) u_timer (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_en       (i_periodic_probe_enable_ch),
        .o_tick     (tick)
    );

    cmd_classify #(.MV_LSB(MV_LSB)) u_class (
        .i_adc      (adc_r),
        .i_step     (step_r),
        .i_thr_code (i_moisture_voltage_threshold),
        .i_ip_code  (i_moisture_target_current),
        .o_gnd      (c_gnd),
        .o_wet      (c_wet),
        .o_done     (c_done),
        .o_open     (c_open),
        .o_dry      (c_dry)
    );

    function [6:0] step_ua;
        input [1:0] s;
        begin
            step_ua = 7'h1 << {s, 1'b0};
        end
    endfunction

    // three-pulse trigger only counts consecutive reduced pulses
    wire three_hit = i_reduced_pulse && (red_cnt_r == `CMD_PULSE_COUNT - 2'h1);   // R6
    // retry enable gates auto triggers once the line was found wet
    wire retry_ok  = !o_channel_wet_flag || i_auto_retry_enable_ch;                // R17
    // detected-phase retry only while already wet, so it never newly sets the flag
    wire auto_trig = retry_ok && ((i_slave_pulse && i_sig_pulse_sent)
                     || three_hit || tick || (i_detected_phase && o_channel_wet_flag)); // R5 R6 R8 R14 R16 R17
    wire man_rise  = i_manual_probe_request_ch && !man_prev_r;                    // R7
    // manual waits for link drop and for converter voltage to leave the line
    wire man_ok    = !i_link_up && !i_conv_on_line;                               // R4 R7
    wire [5:0] lim = `CMD_ADC_FULL - i_adc_range_setting;                         // R10

    assign o_conv_connect_allow = !o_channel_wet_flag && !o_busy;                 // R2 R16

    always @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            red_cnt_r  <= 2'h0;
            man_prev_r <= 1'b0;
        end
        else
        begin
            man_prev_r <= i_manual_probe_request_ch;
            if (i_full_pulse)
                red_cnt_r <= 2'h0;
            else if (three_hit)
                red_cnt_r <= 2'h0;
            else if (i_reduced_pulse)
                red_cnt_r <= red_cnt_r + 2'h1;
        end
    end

    always @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state_r                <= ST_IDLE;
            step_r                 <= 2'h0;
            pend_auto_r            <= 1'b0;
            pend_man_r             <= 1'b0;
            run_auto_r             <= 1'b0;
            first_r                <= 6'h0;
            first_v_r              <= 1'b0;
            vary_r                 <= 1'b0;
            adc_r                  <= 6'h0;
            o_src_en               <= 1'b0;
            o_src_step             <= 2'h0;
            o_adc_req              <= 1'b0;
            o_averaged_adc_reading <= 6'h0;
            o_probe_source_current <= 7'h0;
            o_busy                 <= 1'b0;
            o_res_gnd              <= 1'b0;
            o_res_wet              <= 1'b0;
            o_res_done             <= 1'b0;
            o_res_open             <= 1'b0;
            o_res_abort            <= 1'b0;
            o_channel_wet_flag     <= 1'b0;
        end
        else
        begin
            o_adc_req   <= 1'b0;
            o_res_gnd   <= 1'b0;
            o_res_wet   <= 1'b0;
            o_res_done  <= 1'b0;
            o_res_open  <= 1'b0;
            o_res_abort <= 1'b0;
            // triggers arriving mid-measurement are latched; when a run starts from idle the clear wins
            if (auto_trig)
                pend_auto_r <= 1'b1;                                              // R18
            if (man_rise)
                pend_man_r <= 1'b1;                                               // R4 R7 R18
            // pulses above 17 kohm during wet state clear the flag
            if (o_channel_wet_flag && i_full_pulse && !o_busy)
                o_channel_wet_flag <= 1'b0;                                       // R15
            case (state_r)
                ST_IDLE:
                begin
                    if (pend_auto_r || auto_trig)
                    begin
                        pend_auto_r <= 1'b0;
                        run_auto_r  <= 1'b1;
                        state_r     <= ST_REQ;
                        step_r      <= 2'h0;                                      // R10
                        first_v_r   <= 1'b0;
                        vary_r      <= 1'b0;
                        o_busy      <= 1'b1;
                    end
                    else if (pend_man_r && man_ok)
                    begin
                        pend_man_r <= 1'b0;
                        run_auto_r <= 1'b0;
                        state_r    <= ST_REQ;
                        step_r     <= 2'h0;                                       // R10
                        first_v_r  <= 1'b0;
                        vary_r     <= 1'b0;
                        o_busy     <= 1'b1;
                    end
                end
                ST_REQ:
                begin
                    o_src_en   <= 1'b1;
                    o_src_step <= step_r;
                    o_adc_req  <= 1'b1;
                    state_r    <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (i_adc_valid)
                    begin
                        adc_r <= i_adc_data;
                        // each step should read four times the last; a saturated code says nothing
                        if (first_v_r && i_adc_data != `CMD_ADC_FULL
                            && ({2'h0, i_adc_data} > {first_r, 2'h0} + `CMD_VARY_LIM
                            || {first_r, 2'h0} > {2'h0, i_adc_data} + `CMD_VARY_LIM))
                            vary_r <= 1'b1;                                       // R13
                        first_r   <= i_adc_data;
                        first_v_r <= 1'b1;
                        if (i_adc_data < lim && step_r != `CMD_IP_MAX)
                        begin
                            step_r  <= step_r + 2'h1;                             // R10
                            state_r <= ST_REQ;
                        end
                        else
                            state_r <= ST_DONE;
                    end
                end
                ST_DONE:
                begin
                    o_src_en               <= 1'b0;
                    o_averaged_adc_reading <= adc_r;                              // R11
                    o_probe_source_current <= step_ua(step_r);                    // R11
                    o_busy                 <= 1'b0;
                    state_r                <= ST_IDLE;
                    if (vary_r)
                        o_res_abort <= 1'b1;                                      // R13
                    else
                    begin
                        o_res_gnd  <= c_gnd;                                      // R12
                        o_res_wet  <= c_wet;                                      // R1 R12
                        o_res_done <= c_done;                                     // R12
                        o_res_open <= c_open;                                     // R12
                        if (c_wet && run_auto_r)
                            o_channel_wet_flag <= 1'b1;                           // R14
                        else if (c_dry)
                            o_channel_wet_flag <= 1'b0;                           // R15
                    end
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end
endmodule // cmd_moisture_ctrl

// File: src/cmd_period_timer.v
// Purpose: free running 16 s tick for periodic probing
// Assumes: count parameter shortened in simulation
// Notes:   restarts whenever the enable drops
`timescale 1ns/1ps
`include "cmd_consts.vh"
module cmd_period_timer #(
    parameter [35:0] PERIOD_CYC = `CMD_PERIOD_CYC
) (
    // clock and reset
    input  wire        i_core_clk,
    input  wire        i_resetn,
    // control
    input  wire        i_en,
    output reg         o_tick
);
    reg [35:0] cnt_r;
    always @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            cnt_r  <= 36'h0;
            o_tick <= 1'b0;
        end
        else if (!i_en)
        begin
            cnt_r  <= 36'h0;
            o_tick <= 1'b0;
        end
        else if (cnt_r == PERIOD_CYC - 36'h1)
        begin
            cnt_r  <= 36'h0;
            o_tick <= 1'b1; // R8
        end
        else
        begin
            cnt_r  <= cnt_r + 36'h1;
            o_tick <= 1'b0;
        end
    end
endmodule // cmd_period_timer

// File: test/cmd_checker.sv
// Purpose: port assertions for the moisture probe sequencer
// Assumes: adc answers within 4 cycles of a request
// Notes:   busy bound covers four current steps at that latency
`timescale 1ns/1ps
module cmd_checker (
    input wire       i_core_clk,
    input wire       i_resetn,
    input wire       i_slave_pulse,
    input wire       i_reduced_pulse,
    input wire       i_link_up,
    input wire       i_conv_on_line,
    input wire       i_detected_phase,
    input wire       i_manual_probe_request_ch,
    input wire       i_periodic_probe_enable_ch,
    input wire [5:0] i_adc_range_setting,
    input wire       i_adc_valid,
    input wire [5:0] i_adc_data,
    input wire       o_adc_req,
    input wire [1:0] o_src_step,
    input wire [6:0] o_probe_source_current,
    input wire       o_busy,
    input wire       o_res_gnd,
    input wire       o_res_wet,
    input wire       o_res_done,
    input wire       o_res_open,
    input wire       o_res_abort,
    input wire       o_channel_wet_flag,
    input wire       o_conv_connect_allow
);
    reg  [1:0] vstep_r;
    reg  [7:0] busy_cnt_r;
    wire       any_res = o_res_gnd | o_res_wet | o_res_done | o_res_open | o_res_abort;
    wire       stop    = (i_adc_data >= 6'h3f - i_adc_range_setting) || (o_src_step == 2'h3);
    always @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            vstep_r    <= 2'h0;
            busy_cnt_r <= 8'h00;
        end
        else
        begin
            if (i_adc_valid)
                vstep_r <= o_src_step;
            busy_cnt_r <= o_busy ? busy_cnt_r + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    a_allow_follows_state: assert property (o_conv_connect_allow == !(o_channel_wet_flag || o_busy))
        else $error("connect allow wrong");
    a_manual_starts_run: assert property (($rose(i_manual_probe_request_ch) && !o_busy && !i_link_up
        && !i_conv_on_line) |=> ##1 o_busy) else $error("manual request not started");
    a_link_holds_manual: assert property ((i_link_up && !o_busy && !$past(o_busy) && !i_reduced_pulse
        && !i_slave_pulse && !i_periodic_probe_enable_ch && !i_detected_phase) |=> !o_busy)
        else $error("run during link");
    a_first_step_low: assert property ($rose(o_busy) |=> (o_adc_req && o_src_step == 2'h0))
        else $error("first step not lowest current");
    a_step_quadruples: assert property ((o_busy && i_adc_valid && !stop)
        |=> ##[0:3] (o_adc_req && o_src_step == vstep_r + 2'h1)) else $error("current not stepped up");
    a_run_ends_reported: assert property ((o_busy && i_adc_valid && stop) |-> ##2 (!o_busy && any_res
        && o_probe_source_current == (7'h01 << {vstep_r, 1'b0}))) else $error("run end wrong");
    a_result_one_cycle: assert property (any_res |=> !any_res) else $error("result pulse too long");
    a_flag_from_wet: assert property ($rose(o_channel_wet_flag) |-> (o_res_wet || $past(o_res_wet)))
        else $error("wet flag without wet result");
    a_busy_bounded: assert property (busy_cnt_r < 8'h40) else $error("run too long");
endmodule // cmd_checker
bind cmd_moisture_ctrl cmd_checker i_chk (.i_core_clk, .i_resetn, .i_slave_pulse, .i_reduced_pulse, .i_link_up,
    .i_conv_on_line, .i_detected_phase, .i_manual_probe_request_ch, .i_periodic_probe_enable_ch,
    .i_adc_range_setting, .i_adc_valid, .i_adc_data, .o_adc_req, .o_src_step, .o_probe_source_current, .o_busy,
    .o_res_gnd, .o_res_wet, .o_res_done, .o_res_open, .o_res_abort, .o_channel_wet_flag, .o_conv_connect_allow);

// File: test/cmd_line_model.sv
// Purpose: contact line seen from the case side, answers the probe adc
// Assumes: line resistance in ohm set by the bench, 64 mv per adc code
// Notes:   data line shows a toggling pattern outside valid cycles
`timescale 1ns/1ps
module cmd_line_model (
    // clock and reset
    input  wire        i_core_clk,
    input  wire        i_resetn,
    // line state from the bench
    input  wire [31:0] i_r_ohm,
    input  wire        i_slow,
    input  wire        i_probe,
    // detection pulse return
    output wire        o_reduced,
    output wire        o_full,
    // adc side
    input  wire        i_adc_req,
    input  wire [1:0]  i_src_step,
    output reg         o_adc_valid,
    output reg  [5:0]  o_adc_data
);
    reg [2:0]  cnt_r;
    reg [6:0]  slv_cnt_r;
    reg [39:0] mv_code;
    // low resistance clamps the pulse amplitude
    assign o_reduced = i_probe && (i_r_ohm < 32'd17000);
    assign o_full    = i_probe && (i_r_ohm >= 32'd17000);
    always @*
    begin
        mv_code = ({8'h0, i_r_ohm} << {i_src_step, 1'b0}) / 40'd64000;
    end
    always @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            cnt_r       <= 3'h0;
            slv_cnt_r   <= 7'h0;
            o_adc_valid <= 1'b0;
            o_adc_data  <= 6'h00;
        end
        else
        begin
            o_adc_valid <= 1'b0;
            o_adc_data  <= ~o_adc_data;
            // slave runs its own periodic probe, always on; our reading settles slower then
            slv_cnt_r   <= slv_cnt_r + 7'h1;
            if (i_adc_req)
                cnt_r <= (i_slow || slv_cnt_r[6]) ? 3'h4 : 3'h1;
            else if (cnt_r != 3'h0)
                cnt_r <= cnt_r - 3'h1;
            if (cnt_r == 3'h1 && !i_adc_req)
            begin
                o_adc_valid <= 1'b1;
                // adc saturates at full scale
                o_adc_data  <= (mv_code > 40'd63) ? 6'h3f : mv_code[5:0];
            end
        end
    end
endmodule // cmd_line_model

// File: test/test_contact_moisture_detector.sv
// Purpose: self checking bench for the moisture probe sequencer
// Assumes: 64 mv per adc code, periodic tick shortened to 100 cycles
// Notes:   results checked in order against a queue of expectations
`timescale 1ns/1ps
module test_contact_moisture_detector;
    reg         clk = 1'b0, rstn = 1'b0, slave = 1'b0, sig = 1'b0, probe = 1'b0, link = 1'b0, conv = 1'b0, det = 1'b0;
    reg         man = 1'b0, per_en = 1'b0, retry = 1'b1, slow = 1'b0;
    reg  [7:0]  thr = 8'h46;
    reg  [2:0]  ip = 3'h0;
    reg  [5:0]  rng = 6'h20;
    reg  [31:0] r_ohm = 32'd10000, seed = 32'h465a57ce;
    reg  [31:0] rs [0:4];
    reg  [16:0] q [$];
    integer     n_fail = 0, compares = 0, i;
    wire        red, full, req, vld, busy, gnd, wet, dne, opn, flag, allow, abt;
    wire [1:0]  step;
    wire [5:0]  dat, avg;
    wire [6:0]  cur;
    always #2.5 clk = ~clk;
    cmd_line_model i_line (.i_core_clk(clk), .i_resetn(rstn), .i_r_ohm(r_ohm), .i_slow(slow), .i_probe(probe),
        .o_reduced(red), .o_full(full), .i_adc_req(req), .i_src_step(step), .o_adc_valid(vld), .o_adc_data(dat));
    cmd_moisture_ctrl #(.PERIOD_CYC(36'd100), .MV_LSB(8'h40)) i_dut (.i_core_clk(clk), .i_resetn(rstn),
        .i_slave_pulse(slave), .i_sig_pulse_sent(sig), .i_reduced_pulse(red), .i_full_pulse(full), .i_link_up(link),
        .i_link_drop(1'b0), .i_conv_on_line(conv), .i_detected_phase(det), .i_manual_probe_request_ch(man),
        .i_periodic_probe_enable_ch(per_en), .i_auto_retry_enable_ch(retry), .i_moisture_voltage_threshold(thr),
        .i_moisture_target_current(ip), .i_adc_range_setting(rng), .o_src_en(), .o_src_step(step), .o_adc_req(req),
        .i_adc_valid(vld), .i_adc_data(dat), .o_averaged_adc_reading(avg), .o_probe_source_current(cur),
        .o_busy(busy), .o_res_gnd(gnd), .o_res_wet(wet), .o_res_done(dne), .o_res_open(opn), .o_res_abort(abt),
        .o_channel_wet_flag(flag), .o_conv_connect_allow(allow));
    // stepping and classing worked out from line resistance
    function [16:0] expect_of(input [31:0] r);
        integer s;
        reg [39:0] c, ohm, thr_ohm;
        begin
            s = 0;
            c = ({8'h0, r} << 2 * s) / 40'd64000;
            while ((c > 63 ? 63 : c) < 6'h3f - rng && s < 3)
            begin
                s = s + 1;
                c = ({8'h0, r} << 2 * s) / 40'd64000;
            end
            c = (c > 63) ? 40'd63 : c;
            ohm = c * 40'd64000 / (40'd1 << 2 * s);
            thr_ohm = thr * 40'd10000 / (40'd1 << ip);
            expect_of = {c[5:0], 7'(1 << 2 * s), ohm < 458, ohm < thr_ohm, ohm >= thr_ohm && ohm < 1500000,
                ohm >= 1500000};
        end
    endfunction
    task tick;
        begin
            @(posedge clk);
            #1;
        end
    endtask
    task end_of_test;
        begin
            $display("compares %0d n_fail %0d", compares, n_fail);
            if (n_fail == 0 && compares > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task cmp_bit(input [39:0] name, input e, input g);
        begin
            compares = compares + 1;
            if (g !== e)
            begin
                n_fail = n_fail + 1;
                $display("BAD %s exp %b got %b", name, e, g);
            end
        end
    endtask
    task cmp_res(input [16:0] e, input [16:0] g);
        begin
            compares = compares + 1;
            if (g !== e)
            begin
                n_fail = n_fail + 1;
                $display("BAD result exp %h got %h", e, g);
            end
        end
    endtask
    task wait_busy(input b);
        integer n;
        begin
            n = 0;
            while (busy !== b && n < 300)
            begin
                tick;
                n = n + 1;
            end
            if (busy !== b)
            begin
                n_fail = n_fail + 1;
                $display("BAD busy exp %b got %b", b, busy);
                end_of_test;
            end
        end
    endtask
    // kind 0 manual, 1 slave pulse and signature in the same cycle, 2 three probe pulses, 3 detected phase
    task go(input [1:0] k, input push);
        begin
            if (push)
                q.push_back(expect_of(r_ohm));
            if (k == 2'h0)
            begin
                man = 1'b1;
                tick;
                man = 1'b0;
            end
            else if (k == 2'h1)
            begin
                {slave, sig} = 2'b11;
                tick;
                {slave, sig} = 2'b00;
            end
            else if (k == 2'h3)
            begin
                det = 1'b1;
                tick;
                det = 1'b0;
            end
            else
                repeat (3)
                begin
                    probe = 1'b1;
                    tick;
                    probe = 1'b0;
                    repeat (3) tick;
                end
        end
    endtask
    task run(input [1:0] k);
        begin
            go(k, 1'b1);
            wait_busy(1'b1);
            wait_busy(1'b0);
            cmp_bit("abort", 1'b0, abt);
            tick;
        end
    endtask
    always @(negedge clk)
        if (gnd | wet | dne | opn)
            cmp_res(q.size() ? q.pop_front() : 17'h1ffff, {avg, cur, gnd, wet, dne, opn});
    initial
    begin
        rs[0] = 200; rs[1] = 10000; rs[2] = 200000; rs[3] = 1000000; rs[4] = 3000000;
        @(posedge clk);
        #1 cmp_bit("allow", 1'b1, allow);
        repeat (3) @(posedge clk);
        #1 rstn = 1'b1;
        cmp_bit("busy", 1'b0, busy);
        for (i = 0; i < 5; i = i + 1)
        begin
            r_ohm = rs[i];
            rng = 6'h10 + 6'($random(seed) & 32'h1f);
            slow = i[0];
            run(2'h0);
            cmp_bit("flag", 1'b0, flag);
        end
        {rng, slow, thr, ip, r_ohm} = {6'h20, 1'b0, 8'h0a, 3'h1, 32'd200000};
        run(2'h0);
        {thr, ip} = {8'h46, 3'h0};
        $display("test 1 done");
        for (i = 0; i < 2; i = i + 1)
        begin
            {conv, link} = i ? 2'b10 : 2'b01;
            go(2'h0, 1'b1);
            repeat (20) tick;
            cmp_bit("busy", 1'b0, busy);
            {conv, link} = 2'b00;
            wait_busy(1'b1);
            wait_busy(1'b0);
        end
        r_ohm = 32'd10000;
        run(2'h1);
        cmp_bit("flag", 1'b1, flag);
        cmp_bit("allow", 1'b0, allow);
        retry = 1'b0;
        go(2'h2, 1'b0);
        go(2'h3, 1'b0);
        repeat (20) tick;
        cmp_bit("busy", 1'b0, busy);
        retry = 1'b1;
        run(2'h2);
        cmp_bit("flag", 1'b1, flag);
        run(2'h3);
        cmp_bit("flag", 1'b1, flag);
        r_ohm = 32'd1000000;
        run(2'h1);
        cmp_bit("flag", 1'b0, flag);
        $display("test 2 done");
        r_ohm = 32'd10000;
        q.push_back(expect_of(r_ohm));
        per_en = 1'b1;
        wait_busy(1'b1);
        per_en = 1'b0;
        wait_busy(1'b0);
        tick;
        cmp_bit("flag", 1'b1, flag);
        r_ohm = 32'd200000;
        go(2'h0, 1'b1);
        wait_busy(1'b1);
        go(2'h0, 1'b1);
        wait_busy(1'b0);
        wait_busy(1'b1);
        wait_busy(1'b0);
        repeat (3) tick;
        cmp_bit("queue", 1'b1, q.size() == 0);
        // line changes between the first and second sample, so the readings disagree
        {slow, r_ohm} = {1'b1, 32'd10000};
        go(2'h0, 1'b0);
        wait_busy(1'b1);
        repeat (8) tick;
        r_ohm = 32'd1000000;
        wait_busy(1'b0);
        cmp_bit("abort", 1'b1, abt);
        $display("test 3 done");
        end_of_test;
    end
endmodule // test_contact_moisture_detector
